// >>> design/rmr_pkg.sv
// Register bank package: offsets, field positions, reset values, mode codes.
// Assumes an 8-bit register space reached as 32-bit Avalon words (byte address = 4 * index).
package rmr_pkg;
  localparam int unsigned AW = 7;
  localparam logic [6:0] IDX_DATA_BUF = 7'h00;
  localparam logic [6:0] IDX_OP_MODE = 7'h01;
  localparam logic [6:0] IDX_RSVD_FIRST = 7'h02;
  localparam logic [6:0] IDX_RSVD_LAST = 7'h05;
  localparam logic [6:0] IDX_FREQ_HIGH = 7'h06;
  localparam logic [6:0] IDX_FREQ_MID = 7'h07;
  localparam logic [6:0] IDX_FREQ_LOW = 7'h08;
  localparam logic [6:0] IDX_SHARED_FIRST = 7'h0d;
  localparam logic [6:0] IDX_SHARED_LAST = 7'h3f;
  localparam logic [6:0] IDX_SYNTH_BW = 7'h5c;
  localparam logic [6:0] IDX_LOW_NOISE_BW = 7'h5e;
  localparam logic [6:0] IDX_CAL_TEMP = 7'h6c;
  localparam logic [6:0] IDX_BITRATE_FRAC = 7'h70;
  localparam int unsigned POS_FAMILY = 7;
  localparam int unsigned POS_SHARED = 6;
  localparam int unsigned POS_BW_HI = 7;
  localparam int unsigned POS_BW_LO = 6;
  localparam logic [7:0] RST_DATA_BUF = 8'h00;
  localparam logic [7:0] RST_FREQ_HIGH = 8'he4;
  localparam logic [7:0] RST_FREQ_MID = 8'hc0;
  localparam logic [7:0] RST_FREQ_LOW = 8'h00;
  localparam logic [1:0] RST_LOOP_BW = 2'h3;
  localparam logic [5:0] RST_BW_RSVD = 6'h10;
  localparam logic [7:0] RST_CAL_TEMP = 8'h00;
  localparam logic [3:0] RST_FRAC = 4'h0;
  localparam int unsigned FRAC_DEN = 16;
  localparam int unsigned FREQ_SHIFT = 19;
  localparam int unsigned BUF_DEPTH = 64;
  typedef enum logic [2:0] {
    MODE_SLEEP = 3'h0,
    MODE_STANDBY = 3'h1,
    MODE_TX_SYNTH = 3'h2,
    MODE_TX = 3'h3,
    MODE_RX_SYNTH = 3'h4,
    MODE_RX_CONT = 3'h5,
    MODE_RX_SINGLE = 3'h6,
    MODE_CAD = 3'h7
  } rmr_mode_t;
  localparam rmr_mode_t RST_MODE = MODE_STANDBY;
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_ACK = 3'b010,
    BUS_RELEASE = 3'b100
  } rmr_bus_e;
endpackage

// >>> design/rmr_reset_sync.sv
// Reset release synchroniser for the register bank.
// Assumes reset_n may drop at any time; release is aligned to clk.
`timescale 1ns/1ps
`default_nettype none
module rmr_reset_sync (
  // Clock and raw reset
  input wire logic clk,
  input wire logic reset_n,
  // Synchronised reset
  output logic rst_sync_n
);
  typedef struct packed {
    logic meta;
    logic sync;
  } rmr_rst_s;
  rmr_rst_s st_ff;
  rmr_rst_s nxt_st;
  always_comb begin
    nxt_st.meta = 1'b1;
    nxt_st.sync = st_ff.meta;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign rst_sync_n = st_ff.sync;
endmodule
`default_nettype wire

// >>> design/rmr_data_buffer.sv
// Byte-wide circular data buffer behind the data port.
// Assumes the caller gates pushes and pops; clear empties it in one cycle.
`timescale 1ns/1ps
`default_nettype none
module rmr_data_buffer #(
  parameter int unsigned DEPTH = 64
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic clear,
  input wire logic push,
  input wire logic [7:0] push_data,
  input wire logic pop,
  // Status and data
  output logic [7:0] head_data,
  output logic empty,
  output logic full
);
  localparam int unsigned PW = $clog2(DEPTH);
  typedef struct packed {
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW:0] cnt;
  } rmr_buf_s;
  rmr_buf_s st_ff;
  rmr_buf_s nxt_st;
  logic [7:0] mem [DEPTH];
  logic do_push;
  logic do_pop;
  assign empty = (st_ff.cnt == '0);
  assign full = (st_ff.cnt == (PW+1)'(DEPTH));
  assign do_push = push && !full && !clear;
  assign do_pop = pop && !empty && !clear;
  assign head_data = empty ? 8'h00 : mem[st_ff.rd];
  always_comb begin
    nxt_st = st_ff;
    if (clear) begin
      nxt_st = '0;
    end else begin
      if (do_push) begin
        nxt_st.wr = st_ff.wr + 1'b1;
      end
      if (do_pop) begin
        nxt_st.rd = st_ff.rd + 1'b1;
      end
      if (do_push && !do_pop) begin
        nxt_st.cnt = st_ff.cnt + 1'b1;
      end else if (do_pop && !do_push) begin
        nxt_st.cnt = st_ff.cnt - 1'b1;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  // Storage has no reset; contents are invalid until pushed
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[st_ff.wr] <= push_data;
    end
  end
endmodule
`default_nettype wire

// >>> design/rmr_register_bank.sv
// Radio mode register bank: modem family, operating mode, page switching,
// data port, carrier word, loop bandwidths, calibration temperature, bit-rate fraction.
// Assumes an Avalon-MM master with waitrequest on clk; the modem core supplies
// the temperature capture strobe and reads the configuration outputs.
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rmr_register_bank
  import rmr_pkg::*;
#(
  parameter int unsigned BUF_DEPTH_P = rmr_pkg::BUF_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [8:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  // Modem core side
  input wire logic cal_done,
  input wire logic [7:0] cal_temp_in,
  output logic modem_family_select,
  output logic shared_page_select,
  output logic [2:0] device_mode,
  output logic mode_trigger,
  output logic [23:0] carrier_freq_word,
  output logic freq_change_blocked,
  output logic [1:0] loop_bw_select,
  output logic [1:0] low_noise_bw_select,
  output logic [3:0] divider_fraction,
  output logic fraction_active
);
  import rmr_pkg::*;

  typedef struct packed {
    rmr_bus_e bus;
    logic [31:0] rdata;
    logic [1:0] resp;
    logic family;
    logic shared;
    logic [2:0] mode;
    logic trig;
    logic [7:0] freq_high;
    logic [7:0] freq_mid;
    logic [7:0] freq_low;
    logic [7:0] synth_bw;
    logic [7:0] low_noise_bw;
    logic [7:0] cal_temp;
    logic [3:0] frac;
    logic [7:0] kfifo;
  } rmr_state_s;

  rmr_state_s st_ff;
  rmr_state_s nxt_st;
  logic rst_n;
  logic [6:0] idx;
  logic word_ok;
  logic wr_lane;
  logic [7:0] wbyte;
  logic in_sleep;
  logic keying_page;
  logic idx_common;
  logic idx_shared;
  logic buf_push;
  logic buf_pop;
  logic buf_clear;
  logic [7:0] buf_head;
  logic buf_empty;
  logic buf_full;
  logic access;
  logic [7:0] rbyte;
  logic hit;

  rmr_reset_sync u_reset_sync (
    .clk(clk),
    .reset_n(reset_n),
    .rst_sync_n(rst_n)
  );

  // Decode: byte address is four times the register index
  assign idx = avs_address[8:2];
  assign word_ok = (avs_address[1:0] == 2'b00);
  assign wr_lane = avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];
  assign in_sleep = (st_ff.mode == MODE_SLEEP);
  assign access = (avs_read || avs_write) && (st_ff.bus == BUS_IDLE) && word_ok;
  // Keying page visible when keying family, or long-range with shared page set for indexes 0x0d to 0x3f only
  assign idx_shared = (idx >= IDX_SHARED_FIRST) && (idx <= IDX_SHARED_LAST);
  assign keying_page = !st_ff.family || (st_ff.shared && idx_shared);
  assign idx_common = (idx < IDX_SHARED_FIRST);

  // Data port: inert and held empty while sleeping
  assign buf_clear = in_sleep;
  assign buf_push = access && avs_write && wr_lane && idx == IDX_DATA_BUF && !in_sleep;
  assign buf_pop = access && avs_read && idx == IDX_DATA_BUF && !in_sleep;

  rmr_data_buffer #(
    .DEPTH(BUF_DEPTH_P)
  ) u_data_buffer (
    .clk(clk),
    .rst_n(rst_n),
    .clear(buf_clear),
    .push(buf_push),
    .push_data(wbyte),
    .pop(buf_pop),
    .head_data(buf_head),
    .empty(buf_empty),
    .full(buf_full)
  );

  // Read mux
  always_comb begin
    rbyte = 8'h00;
    hit = 1'b1;
    if (idx_common) begin
      unique case (idx)
        IDX_DATA_BUF: rbyte = in_sleep ? 8'h00 : buf_head;
        IDX_OP_MODE: rbyte = {st_ff.family, st_ff.shared, 3'b000, st_ff.mode};
        IDX_FREQ_HIGH: rbyte = st_ff.freq_high;
        IDX_FREQ_MID: rbyte = st_ff.freq_mid;
        IDX_FREQ_LOW: rbyte = st_ff.freq_low;
        default: rbyte = 8'h00;
      endcase
    end else if (keying_page) begin
      unique case (idx)
        IDX_SYNTH_BW: rbyte = st_ff.synth_bw;
        IDX_LOW_NOISE_BW: rbyte = st_ff.low_noise_bw;
        IDX_CAL_TEMP: rbyte = st_ff.cal_temp;
        IDX_BITRATE_FRAC: rbyte = {4'h0, st_ff.frac};
        default: begin
          rbyte = 8'h00;
          hit = 1'b0;
        end
      endcase
    end else begin
      // Long-range page holds no registers in this bank
      hit = 1'b0;
    end
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.trig = 1'b0;
    unique case (st_ff.bus)
      BUS_IDLE: begin
        if ((avs_read || avs_write) && !word_ok) begin
          nxt_st.bus = BUS_ACK;
          nxt_st.rdata = 32'h0000_0000;
          nxt_st.resp = 2'b10;
        end else if (access) begin
          nxt_st.bus = BUS_ACK;
          nxt_st.rdata = {24'h00_0000, rbyte};
          nxt_st.resp = hit ? 2'b00 : 2'b11;
        end
      end
      BUS_ACK: begin
        nxt_st.bus = BUS_RELEASE;
      end
      BUS_RELEASE: begin
        nxt_st.bus = BUS_IDLE;
      end
      default: nxt_st.bus = BUS_IDLE;
    endcase

    if (access && avs_write && wr_lane) begin
      if (idx_common) begin
        unique case (idx)
          IDX_OP_MODE: begin
            if (in_sleep) begin
              nxt_st.family = wbyte[POS_FAMILY];
            end
            nxt_st.shared = wbyte[POS_SHARED];
            nxt_st.mode = wbyte[2:0];
            nxt_st.trig = 1'b1;
          end
          IDX_FREQ_HIGH: nxt_st.freq_high = wbyte;
          IDX_FREQ_MID: nxt_st.freq_mid = wbyte;
          IDX_FREQ_LOW: nxt_st.freq_low = wbyte;
          default: nxt_st.freq_low = st_ff.freq_low;
        endcase
      end else if (keying_page) begin
        unique case (idx)
          IDX_SYNTH_BW: nxt_st.synth_bw = wbyte;
          IDX_LOW_NOISE_BW: nxt_st.low_noise_bw = wbyte;
          IDX_CAL_TEMP: nxt_st.cal_temp = wbyte;
          IDX_BITRATE_FRAC: nxt_st.frac = wbyte[3:0];
          default: nxt_st.frac = st_ff.frac;
        endcase
      end
    end
    // Hardware capture wins over a software write in the same cycle
    if (cal_done) begin
      nxt_st.cal_temp = cal_temp_in;
    end
    nxt_st.kfifo = {7'h00, buf_full};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff.bus <= BUS_IDLE;
      st_ff.rdata <= 32'h0000_0000;
      st_ff.resp <= 2'b00;
      st_ff.family <= 1'b0;
      st_ff.shared <= 1'b0;
      st_ff.mode <= RST_MODE;
      st_ff.trig <= 1'b0;
      st_ff.freq_high <= RST_FREQ_HIGH;
      st_ff.freq_mid <= RST_FREQ_MID;
      st_ff.freq_low <= RST_FREQ_LOW;
      st_ff.synth_bw <= {RST_LOOP_BW, RST_BW_RSVD};
      st_ff.low_noise_bw <= {RST_LOOP_BW, RST_BW_RSVD};
      st_ff.cal_temp <= RST_CAL_TEMP;
      st_ff.frac <= RST_FRAC;
      st_ff.kfifo <= 8'h00;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Bus answers one cycle after the request is first seen
  assign avs_waitrequest = (avs_read || avs_write) && (st_ff.bus != BUS_ACK);
  assign avs_readdata = st_ff.rdata;
  assign avs_response = st_ff.resp;

  assign modem_family_select = st_ff.family;
  assign shared_page_select = st_ff.shared;
  assign device_mode = st_ff.mode;
  assign mode_trigger = st_ff.trig;
  assign carrier_freq_word = {st_ff.freq_high, st_ff.freq_mid, st_ff.freq_low};
  // Flags a carrier word that may be changing outside sleep or standby
  assign freq_change_blocked = !(st_ff.mode == MODE_SLEEP || st_ff.mode == MODE_STANDBY);
  assign loop_bw_select = st_ff.synth_bw[POS_BW_HI:POS_BW_LO];
  assign low_noise_bw_select = st_ff.low_noise_bw[POS_BW_HI:POS_BW_LO];
  assign divider_fraction = st_ff.frac;
  // Fraction used only in keying family and when nonzero
  assign fraction_active = !st_ff.family && (st_ff.frac != 4'h0);
endmodule
`default_nettype wire

// >>> test/rmr_register_bank_sva.sv
// Checker for the radio mode register bank, bound to its top module.
// Assumes one clock and the raw active-low reset at the top ports.
`timescale 1ns/1ps
`default_nettype none
module rmr_register_bank_sva
  import rmr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Avalon-MM
  input wire logic [8:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  // Modem side
  input wire logic modem_family_select,
  input wire logic shared_page_select,
  input wire logic [2:0] device_mode,
  input wire logic mode_trigger,
  input wire logic [23:0] carrier_freq_word,
  input wire logic freq_change_blocked,
  input wire logic [1:0] loop_bw_select,
  input wire logic [1:0] low_noise_bw_select,
  input wire logic [3:0] divider_fraction,
  input wire logic fraction_active
);
  logic [6:0] idx;
  logic wr_ok;
  logic rd_ok;
  assign idx = avs_address[8:2];
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign rd_ok = avs_read && !avs_waitrequest;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_MODE_SET: assert property (wr_ok && idx == IDX_OP_MODE |=>
    device_mode == $past(avs_writedata[2:0])) else $error("mode field not taken");
  AST_MODE_PULSE: assert property (wr_ok && idx == IDX_OP_MODE |-> mode_trigger ##1 !mode_trigger)
    else $error("no mode trigger");
  AST_FAMILY_SLEEP: assert property (!$stable(modem_family_select) |->
    $past(device_mode) == MODE_SLEEP) else $error("family changed outside sleep");
  AST_SHARED_SET: assert property (wr_ok && idx == IDX_OP_MODE |=>
    shared_page_select == $past(avs_writedata[6])) else $error("shared bit not taken");
  AST_BW_MAIN: assert property (wr_ok && idx == IDX_SYNTH_BW && !modem_family_select |=>
    loop_bw_select == $past(avs_writedata[7:6])) else $error("loop bandwidth wrong");
  AST_BW_LOWPN: assert property (wr_ok && idx == IDX_LOW_NOISE_BW && !modem_family_select |=>
    low_noise_bw_select == $past(avs_writedata[7:6])) else $error("low noise bandwidth wrong");
  AST_FRAC: assert property (fraction_active == (!modem_family_select && divider_fraction != 4'h0))
    else $error("fraction active wrong");
  AST_FREQ_HIGH: assert property (wr_ok && idx == IDX_FREQ_HIGH |=>
    carrier_freq_word[23:16] == $past(avs_writedata[7:0])) else $error("carrier high byte wrong");
  AST_BLOCKED: assert property (freq_change_blocked == !(device_mode inside {MODE_SLEEP, MODE_STANDBY}))
    else $error("carrier block flag wrong");
  AST_RSVD_ZERO: assert property (rd_ok && idx inside {[IDX_RSVD_FIRST:IDX_RSVD_LAST]} |->
    avs_readdata == 32'h0) else $error("reserved read not zero");
  AST_BUF_SLEEP: assert property (rd_ok && idx == IDX_DATA_BUF && device_mode == MODE_SLEEP |->
    avs_readdata[7:0] == 8'h00) else $error("data port live in sleep");
  AST_HIDDEN: assert property (rd_ok && modem_family_select && idx > IDX_SHARED_LAST |->
    avs_response == 2'h3) else $error("keying page visible");
  cover property (wr_ok && idx == IDX_OP_MODE);
  cover property ($rose(modem_family_select));
  cover property (rd_ok && avs_response == 2'h3);
endmodule
bind rmr_register_bank rmr_register_bank_sva i_rmr_register_bank_sva (.clk, .reset_n, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
  .avs_response, .modem_family_select, .shared_page_select, .device_mode, .mode_trigger,
  .carrier_freq_word, .freq_change_blocked, .loop_bw_select, .low_noise_bw_select,
  .divider_fraction, .fraction_active);
`default_nettype wire

// >>> test/rmr_register_bank_bench.sv
// Self-checking bench for the radio mode register bank.
// Assumes the bound checker and an Avalon-MM master driven from here.
`timescale 1ns/1ps
`default_nettype none
module rmr_register_bank_bench;
  import rmr_pkg::*;
  logic clk, reset_n, avs_read, avs_write, avs_waitrequest, cal_done;
  logic modem_family_select, shared_page_select, mode_trigger, freq_change_blocked, fraction_active;
  logic [8:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable, divider_fraction;
  logic [1:0] avs_response, loop_bw_select, low_noise_bw_select, gresp;
  logic [7:0] cal_temp_in, got;
  logic [2:0] device_mode;
  logic [23:0] carrier_freq_word;
  int err_total, total_checks;
  // Row: {write flag and index, write data, expected read}
  logic [23:0] rows [15] = '{24'h5c00d0, 24'h5e00d0, 24'h0600e4, 24'h0700c0, 24'h080000,
    24'h010001, 24'h6c0000, 24'h700000, 24'h83ff00, 24'h85a500, 24'hdc5050, 24'hde9090,
    24'hf0ff0f, 24'h80a5a5, 24'h881212};
  rmr_register_bank i_rmr_register_bank (.clk, .reset_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response, .cal_done,
    .cal_temp_in, .modem_family_select, .shared_page_select, .device_mode, .mode_trigger,
    .carrier_freq_word, .freq_change_blocked, .loop_bw_select, .low_noise_bw_select,
    .divider_fraction, .fraction_active);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic [6:0] i, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= {i, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    // Request stands until a rising edge sees waitrequest low
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      err_total++;
      end_of_test;
    end
    got = avs_readdata[7:0];
    gresp = avs_response;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic end_of_test;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    end_of_test;
  end
  initial begin
    reset_n = 1'b0;
    {avs_read, avs_write, cal_done} = 3'h0;
    avs_address = 9'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h1;
    cal_temp_in = 8'h00;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (rows[k]) begin
      if (rows[k][23]) acc(1'b1, rows[k][22:16], rows[k][15:8]);
      acc(1'b0, rows[k][22:16], 8'h00);
      chk(32'(got), 32'(rows[k][7:0]));
    end
    @(negedge clk);
    chk(32'({loop_bw_select, low_noise_bw_select, divider_fraction}), 32'h6f);
    chk(32'(fraction_active), 32'h1);
    chk(32'(carrier_freq_word), 32'he4c012);
    for (int m = 7; m >= 0; m--) begin
      acc(1'b1, IDX_OP_MODE, 8'(m));
      @(negedge clk);
      chk(32'({device_mode, freq_change_blocked}), 32'({3'(m), m > 1}));
    end
    acc(1'b1, IDX_DATA_BUF, 8'h11);
    acc(1'b0, IDX_DATA_BUF, 8'h00);
    chk(32'(got), 32'h0);
    acc(1'b1, IDX_OP_MODE, 8'h80);
    acc(1'b0, IDX_SYNTH_BW, 8'h00);
    chk(32'({gresp, got}), 32'h300);
    acc(1'b1, IDX_OP_MODE, 8'hc1);
    @(negedge clk);
    chk(32'({modem_family_select, shared_page_select, fraction_active}), 32'h6);
    acc(1'b1, IDX_OP_MODE, 8'h01);
    @(negedge clk);
    chk(32'({modem_family_select, shared_page_select}), 32'h2);
    acc(1'b1, IDX_OP_MODE, 8'h80);
    acc(1'b1, IDX_OP_MODE, 8'h00);
    @(negedge clk);
    chk(32'(modem_family_select), 32'h0);
    @(posedge clk);
    cal_temp_in <= 8'h3c;
    cal_done <= 1'b1;
    @(posedge clk);
    cal_done <= 1'b0;
    acc(1'b0, IDX_CAL_TEMP, 8'h00);
    chk(32'(got), 32'h3c);
    end_of_test;
  end
endmodule
`default_nettype wire
